// >>> inc/charger_pin_params.svh
// Constants for the charger pin control arbiter
`ifndef CHARGER_PIN_PARAMS_SVH
`define CHARGER_PIN_PARAMS_SVH
// Register offsets
`define REG_CHG_CTRL        8'h07
`define REG_IRQ_ENABLE      8'h09
`define REG_IRQ_STATUS      8'h0A
`define REG_IRQ_CLEAR       8'h0B
`define REG_ILIM_CTRL       8'h0C
`define REG_MODE_STATUS     8'h0D
// Field positions in the charge control register
`define BIT_CHG_ENABLE      0
`define BIT_CHIP_DISABLE    6
// Interrupt event positions
`define IRQ_SUPPLY_CHANGE   0
`define IRQ_BATT_OK         1
`define IRQ_EXT_EVENT       2
`define IRQ_WIDTH           3
// Reset values
`define RST_IRQ_ENABLE      3'h0
// Input current limits in mA
`define ILIM_LOW_MA         16'h0064
`define ILIM_HIGH_MA        16'h01F4
`endif

// >>> inc/charger_pin_pkg.sv
// Types for the charger pin control arbiter
package charger_pin_pkg;
  typedef enum logic [1:0] {VAR_DISABLE_CHARGE, VAR_CHARGE_IRQ} variant_t;
  typedef logic [7:0] reg_addr_t;
endpackage : charger_pin_pkg

// >>> hdl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Pin and filtered level
  input  wire logic pinIn,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // First stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Change counts once stages two and three agree; floating reads low
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      level <= 1'b0;
    else if (s2 == s3)
      level <= s2;
  end
endmodule : pin_sync

// >>> hdl/charger_pin_control_arbiter.sv
// Pin and register arbitration for charger control
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "charger_pin_params.svh"
module charger_pin_control_arbiter
#(
  parameter charger_pin_pkg::variant_t VARIANT = charger_pin_pkg::VAR_DISABLE_CHARGE
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Control pins
  input  wire logic        current_limit_select_pin,
  input  wire logic        second_config_pin,
  input  wire logic        third_config_pin_in,
  output logic             third_config_pin_out,
  output logic             third_config_pin_oe_n,
  // Analog status inputs, same clock
  input  wire logic        usb_supply_input,
  input  wire logic        battWeakReached,
  input  wire logic        extEvent,
  input  wire logic        indicatorRequest,
  // Open-drain outputs
  output logic             battery_ok_output_out,
  output logic             battery_ok_output_oe_n,
  output logic             indicator_lamp_output_out,
  output logic             indicator_lamp_output_oe_n,
  // Control results
  output logic [15:0]      inputLimitMa,
  output logic             chipDisable,
  output logic             systemRegEnable,
  output logic             chargeEnable,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  // Interrupt
  output logic             irq
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ilimPin;
  logic secondPin;
  logic thirdPin;

  pin_sync u_sync_ilim
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (current_limit_select_pin),
    .level   (ilimPin)
  );
  pin_sync u_sync_second
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (second_config_pin),
    .level   (secondPin)
  );
  pin_sync u_sync_third
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pinIn   (third_config_pin_in),
    .level   (thirdPin)
  );

  // Variant decode: where the charge enable and disable come from
  localparam logic HAS_DISABLE = (VARIANT == charger_pin_pkg::VAR_DISABLE_CHARGE);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // Register value once written, pin level until then
  function automatic logic pick(input logic ovr, input logic regVal, input logic pinVal);
    pick = ovr ? regVal : pinVal;
  endfunction : pick

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // One strobe per writable register, shared by every consumer
  logic wrChg;
  logic wrIlim;
  logic wrIrqEnable;
  logic wrIrqClear;

  assign wrChg       = wr && hit(addr, `REG_CHG_CTRL);
  assign wrIlim      = wr && hit(addr, `REG_ILIM_CTRL);
  assign wrIrqEnable = wr && hit(addr, `REG_IRQ_ENABLE);
  assign wrIrqClear  = wr && hit(addr, `REG_IRQ_CLEAR);

  // ----------------------------------------
  // Supply attach and detach detection
  // ----------------------------------------
  logic supplyPrev;
  logic supplyEdge;

  // Tracks the level through reset too, so no false edge at release
  always_ff @(posedge ref_clk)
  begin
    supplyPrev <= usb_supply_input;
  end
  assign supplyEdge = usb_supply_input ^ supplyPrev;

  // ----------------------------------------
  // Register overrides
  // ----------------------------------------
  logic ovrIlim;
  logic regIlim;
  logic ovrChg;
  logic regChg;
  logic ovrDis;
  logic regDis;

  // Supply edge wins over a same-cycle write: an attach or a detach resets control
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || supplyEdge)
    begin
      ovrChg <= 1'b0;
      regChg <= 1'b0;
      ovrDis <= 1'b0;
      regDis <= 1'b0;
    end
    else if (wrChg)
    begin
      ovrChg <= 1'b1;
      regChg <= wdata[`BIT_CHG_ENABLE];
      ovrDis <= HAS_DISABLE;
      regDis <= wdata[`BIT_CHIP_DISABLE];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst || supplyEdge)
    begin
      ovrIlim <= 1'b0;
      regIlim <= 1'b0;
    end
    else if (wrIlim)
    begin
      ovrIlim <= 1'b1;
      regIlim <= wdata[0];
    end
  end

  // ----------------------------------------
  // Effective control values
  // ----------------------------------------
  logic effIlim;
  logic effDis;
  logic effChg;

  always_comb
  begin
    effIlim = pick(ovrIlim, regIlim, ilimPin);
    effDis  = HAS_DISABLE && pick(ovrDis, regDis, secondPin);
    if (ovrChg)
      effChg = regChg;
    else
      effChg = HAS_DISABLE ? thirdPin : secondPin;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      inputLimitMa    <= `ILIM_LOW_MA;
      chipDisable     <= 1'b0;
      systemRegEnable <= 1'b0;
      chargeEnable    <= 1'b0;
    end
    else
    begin
      inputLimitMa    <= effIlim ? `ILIM_HIGH_MA : `ILIM_LOW_MA;
      chipDisable     <= effDis;
      systemRegEnable <= !effDis;
      chargeEnable    <= effChg && !effDis;
    end
  end

  // ----------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------
  logic [`IRQ_WIDTH-1:0] irqStatus;
  logic [`IRQ_WIDTH-1:0] irqEnable;
  logic [`IRQ_WIDTH-1:0] irqEvents;
  logic [`IRQ_WIDTH-1:0] irqClear;
  logic                  battPrev;

  // Level already reached at release is not a new event
  always_ff @(posedge ref_clk)
  begin
    battPrev <= battWeakReached;
  end

  always_comb
  begin
    irqEvents = '0;
    irqEvents[`IRQ_SUPPLY_CHANGE] = supplyEdge;
    irqEvents[`IRQ_BATT_OK]       = battWeakReached && !battPrev;
    irqEvents[`IRQ_EXT_EVENT]     = extEvent;
    irqClear = wrIrqClear ? wdata[`IRQ_WIDTH-1:0] : '0;
  end

  // Set beats a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      irqStatus <= '0;
    else
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      irqEnable <= `RST_IRQ_ENABLE;
    else if (wrIrqEnable)
      irqEnable <= wdata[`IRQ_WIDTH-1:0];
  end

  logic irqPending;
  assign irqPending = |(irqStatus & irqEnable);

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= irqPending;
  end

  // ----------------------------------------
  // Open-drain pins
  // ----------------------------------------
  // Pins only ever pull low; enable is active low
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      third_config_pin_out       <= 1'b0;
      third_config_pin_oe_n      <= 1'b1;
      battery_ok_output_out      <= 1'b0;
      battery_ok_output_oe_n     <= 1'b1;
      indicator_lamp_output_out  <= 1'b0;
      indicator_lamp_output_oe_n <= 1'b1;
    end
    else
    begin
      third_config_pin_oe_n      <= !(!HAS_DISABLE && irqPending);
      battery_ok_output_oe_n     <= !battWeakReached;
      indicator_lamp_output_oe_n <= !indicatorRequest;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (hit(addr, `REG_CHG_CTRL))
      begin
        rdata <= 8'h00;
        rdata[`BIT_CHG_ENABLE]   <= effChg;
        rdata[`BIT_CHIP_DISABLE] <= effDis;
      end
      else if (hit(addr, `REG_IRQ_ENABLE))
        rdata <= {5'h0, irqEnable};
      else if (hit(addr, `REG_IRQ_STATUS))
        rdata <= {5'h0, irqStatus};
      else if (hit(addr, `REG_ILIM_CTRL))
        rdata <= {7'h0, effIlim};
      else if (hit(addr, `REG_MODE_STATUS))
        rdata <= {2'h0, ovrIlim, ovrChg, ovrDis, ilimPin, secondPin, thirdPin};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end
endmodule : charger_pin_control_arbiter

// >>> verification/host_pins_model.sv
// Host-side pin drivers with the pull-down seen on a floating pin
`timescale 1ns/1ps
module host_pins_model
(
  // Requested levels and float controls
  input  wire logic [2:0] lvl,
  input  wire logic [2:0] flt,
  // Pins as the device sees them
  output logic      [2:0] pin
);
  // Undriven pins settle low through the pull-down, never hold old level
  assign pin = lvl & ~flt;
endmodule : host_pins_model

// >>> verification/charger_pin_control_arbiter_checker.sv
// Port assertions for the charger pin control arbiter
`timescale 1ns/1ps
module charger_pin_control_arbiter_checker
#(
  parameter charger_pin_pkg::variant_t VARIANT = charger_pin_pkg::VAR_DISABLE_CHARGE
)
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // Inputs watched
  input wire logic        current_limit_select_pin,
  input wire logic        usb_supply_input,
  input wire logic        battWeakReached,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        indicatorRequest,
  // Outputs watched
  input wire logic        third_config_pin_out,
  input wire logic        third_config_pin_oe_n,
  input wire logic        battery_ok_output_out,
  input wire logic        battery_ok_output_oe_n,
  input wire logic        indicator_lamp_output_out,
  input wire logic        indicator_lamp_output_oe_n,
  input wire logic [15:0] inputLimitMa,
  input wire logic        chipDisable,
  input wire logic        systemRegEnable,
  input wire logic        chargeEnable,
  input wire logic [7:0]  rdata,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ilim_value_a: assert property (inputLimitMa == 16'h0064 || inputLimitMa == 16'h01F4)
    else $error("limit not 100 or 500");
  disable_off_a: assert property ($past(nrst)
    |-> systemRegEnable == !chipDisable && !(chipDisable && chargeEnable))
    else $error("disable not shutting down");
  batt_ok_a: assert property (1 |=> battery_ok_output_oe_n != $past(battWeakReached))
    else $error("battery ok pin wrong");
  drain_low_a: assert property (!third_config_pin_out && !battery_ok_output_out && !indicator_lamp_output_out)
    else $error("open drain drives high");
  irq_pin_a: assert property (VARIANT != charger_pin_pkg::VAR_CHARGE_IRQ |-> third_config_pin_oe_n)
    else $error("third pin pulled in wrong variant");
  chg_reg_a: assert property (wr && addr == 8'h07 && !wdata[6] && $stable(usb_supply_input)
    ##1 (!wr && $stable(usb_supply_input))[*2] |-> chargeEnable == $past(wdata[0], 2))
    else $error("charge bit not followed");
  supply_pins_a: assert property ($changed(usb_supply_input) && !$past(wr) ##0
    (!wr && $stable(current_limit_select_pin))[*8]
    |-> inputLimitMa == (current_limit_select_pin ? 16'h01F4 : 16'h0064))
    else $error("supply edge kept override");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read");
  irq_pin_match_a: assert property (VARIANT == charger_pin_pkg::VAR_CHARGE_IRQ
    |-> third_config_pin_oe_n == !irq)
    else $error("interrupt pin disagrees with irq");
  lamp_follow_a: assert property ($past(nrst) |-> indicator_lamp_output_oe_n == !$past(indicatorRequest))
    else $error("lamp pin not following request");
  cover property (wr && addr == 8'h07);
  cover property ($changed(usb_supply_input));
  cover property (rd ##1 rdata != 8'h00);
  cover property (third_config_pin_oe_n == 1'b0);
endmodule : charger_pin_control_arbiter_checker

bind charger_pin_control_arbiter charger_pin_control_arbiter_checker #(.VARIANT(VARIANT)) i_checker (.*);

// >>> verification/charger_pin_control_arbiter_bench.sv
// Self-checking bench for the charger pin control arbiter
`timescale 1ns/1ps
module charger_pin_control_arbiter_bench;
  logic ref_clk = 0, nrst = 0, usb_supply_input = 0, battWeakReached = 0, extEvent = 0;
  logic indicatorRequest = 0, wr = 0, rd = 0;
  logic [2:0] lvl = 3'h0, flt = 3'h0, pin;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] inputLimitMa;
  logic chipDisable, systemRegEnable, chargeEnable, irq, battery_ok_output_oe_n, indicator_lamp_output_oe_n;
  logic chargeEnableAlt, chipDisableAlt, thirdOeAlt;
  int errors = 0, total_checks = 0, cycles = 0, seed = 66845, expIlim, expDis, expChg;
  always #2 ref_clk = ~ref_clk;
  host_pins_model i_host_pins_model (.lvl, .flt, .pin);
  charger_pin_control_arbiter i_charger_pin_control_arbiter (.ref_clk, .nrst,
    .current_limit_select_pin(pin[0]), .second_config_pin(pin[1]), .third_config_pin_in(pin[2]),
    .third_config_pin_out(), .third_config_pin_oe_n(), .usb_supply_input, .battWeakReached,
    .extEvent, .indicatorRequest, .battery_ok_output_out(), .battery_ok_output_oe_n,
    .indicator_lamp_output_out(), .indicator_lamp_output_oe_n, .inputLimitMa, .chipDisable,
    .systemRegEnable, .chargeEnable, .addr, .wdata, .wr, .rd, .rdata, .irq);
  // Second variant: charge enable on the second pin, interrupt on the third
  if (1)
  begin : alt
    charger_pin_control_arbiter #(.VARIANT(charger_pin_pkg::VAR_CHARGE_IRQ)) i_charger_pin_control_arbiter (
      .ref_clk, .nrst, .current_limit_select_pin(pin[0]), .second_config_pin(pin[1]),
      .third_config_pin_in(pin[2]), .third_config_pin_out(), .third_config_pin_oe_n(thirdOeAlt),
      .usb_supply_input, .battWeakReached, .extEvent, .indicatorRequest, .battery_ok_output_out(),
      .battery_ok_output_oe_n(), .indicator_lamp_output_out(), .indicator_lamp_output_oe_n(),
      .inputLimitMa(), .chipDisable(chipDisableAlt), .systemRegEnable(), .chargeEnable(chargeEnableAlt),
      .addr, .wdata, .wr, .rd, .rdata(), .irq());
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdReg
  task automatic pulseEvent;
    @(posedge ref_clk);
    extEvent <= 1'b1;
    @(posedge ref_clk);
    extEvent <= 1'b0;
    step(3);
  endtask : pulseEvent
  task automatic print_verdict;
    $display("errors %0d of %0d checks", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Long enough for the whole sequence, short enough to cut a hang
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    step(8);
    nrst <= 1'b1;
    step(1);
    #1 chk(inputLimitMa, 16'h0064);
    for (int i = 0; i < 12; i++)
    begin
      step(1);
      lvl <= 3'($random(seed));
      flt <= 3'($random(seed));
      battWeakReached <= 1'($random(seed));
      indicatorRequest <= 1'($random(seed));
      step(10);
      expIlim = (lvl[0] & ~flt[0]) ? 500 : 100;
      expDis = lvl[1] & ~flt[1];
      expChg = lvl[2] & ~flt[2] & ~expDis;
      #1 chk(inputLimitMa, expIlim);
      chk(chipDisable, expDis);
      chk(systemRegEnable, !expDis);
      chk(chargeEnable, expChg);
      chk(battery_ok_output_oe_n, !battWeakReached);
      chk(chargeEnableAlt, lvl[1] & ~flt[1]);
      chk(chipDisableAlt, 0);
      chk(indicator_lamp_output_oe_n, !indicatorRequest);
    end
    step(1);
    lvl <= 3'h0;
    flt <= 3'h0;
    step(10);
    wrReg(8'h07, 8'h01);
    wrReg(8'h0C, 8'h01);
    step(3);
    #1 chk(chargeEnable, 1);
    chk(inputLimitMa, 16'h01F4);
    chk(chargeEnableAlt, 1);
    wrReg(8'h07, 8'h40);
    step(1);
    lvl <= 3'h4;
    step(10);
    #1 chk(chipDisable, 1);
    chk(chargeEnable, 0);
    chk(chipDisableAlt, 0);
    chk(chargeEnableAlt, 0);
    step(1);
    usb_supply_input <= 1'b1;
    step(10);
    #1 chk(chargeEnable, 1);
    chk(inputLimitMa, 16'h0064);
    wrReg(8'h09, 8'h04);
    wrReg(8'h0B, 8'h07);
    step(3);
    #1 chk(irq, 0);
    pulseEvent();
    #1 chk(irq, 1);
    chk(thirdOeAlt, 0);
    rdReg(8'h0A, 8'h04);
    wrReg(8'h0B, 8'h04);
    step(3);
    #1 chk(irq, 0);
    chk(thirdOeAlt, 1);
    wrReg(8'h09, 8'h00);
    pulseEvent();
    #1 chk(irq, 0);
    chk(thirdOeAlt, 1);
    rdReg(8'h20, 8'h00);
    print_verdict;
  end
endmodule : charger_pin_control_arbiter_bench
